/* File: sps_pkg.sv */
package sps_pkg;

   // Register byte offsets
   localparam logic [7:0] SPS_OFF_STATUS = 8'h00;
   localparam logic [7:0] SPS_OFF_CONTROL = 8'h04;
   localparam logic [7:0] SPS_OFF_BUFFER = 8'h08;
   localparam logic [7:0] SPS_OFF_OWN_ADDR = 8'h0c;

   // Status field positions
   localparam int SPS_ST_SAMPLE = 7;
   localparam int SPS_ST_LEVEL_SEL = 6;
   localparam int SPS_ST_DATA_ADDR = 5;
   localparam int SPS_ST_STOP = 4;
   localparam int SPS_ST_START = 3;
   localparam int SPS_ST_RW = 2;
   localparam int SPS_ST_ADDR_UPDATE = 1;
   localparam int SPS_ST_BUF_FULL = 0;

   // Control field positions
   localparam int SPS_CT_ENABLE = 0;
   localparam int SPS_CT_I2C = 1;
   localparam int SPS_CT_MASTER = 2;
   localparam int SPS_CT_TEN_BIT = 3;
   localparam int SPS_CT_REQ_LSB = 4;
   localparam int SPS_REQ_W = 5;

   // Reset values
   localparam logic [7:0] SPS_STATUS_RST = 8'h00;
   localparam logic [8:0] SPS_CONTROL_RST = 9'h000;
   localparam logic [7:0] SPS_BYTE_RST = 8'h00;

   // Master request bits, one per sequence
   typedef struct packed {
      logic ack_seq;
      logic receive;
      logic stop;
      logic repeat_start;
      logic start;
   } sps_req_t;

   // Control layout, msb first, matches the field positions above
   typedef struct packed {
      sps_req_t req;
      logic ten_bit;
      logic master_mode;
      logic i2c_mode;
      logic port_enable;
   } sps_ctrl_t;

   // Events from the serial bus engine, one-cycle pulses
   typedef struct packed {
      logic start_seen;
      logic stop_seen;
      logic addr_match;
      logic addr_rw;
      logic nack_seen;
      logic byte_done;
      logic byte_is_data;
      logic rx_done;
      logic [7:0] rx_byte;
      logic tx_bits_done;
      logic tx_ack_done;
      logic addr_reload_needed;
      sps_req_t req_done;
   } sps_evt_t;

endpackage

/* File: sps_flag.sv */
`timescale 1ns/1ns
module sps_flag
   import sps_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic load,
   input wire logic load_val,
   input wire logic clr,
   input wire logic kill,
   // State
   output logic q
);

   logic q_reg;
   logic q_next;

   // Kill first, load beats clear
   always_comb begin
      q_next = q_reg;
      if (kill) begin
         q_next = 1'b0;
      end else if (load) begin
         q_next = load_val;
      end else if (clr) begin
         q_next = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_reg <= 1'b0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign q = q_reg;

endmodule

/* File: sps_apb.sv */
`timescale 1ns/1ns
module sps_apb
   import sps_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB request
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   // Decode from owner
   input wire logic hit,
   input wire logic [31:0] rdata_in,
   // APB answer
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Strobes at completion
   output logic wr_stb,
   output logic rd_stb
);

   logic pready_reg;
   logic pready_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic setup;
   logic done;

   assign setup = psel && !penable;
   assign done = psel && penable && pready_reg;

   // Answer is captured in setup, shown for one access cycle
   always_comb begin
      pready_next = setup;
      prdata_next = 32'h0000_0000;
      pslverr_next = 1'b0;
      if (setup) begin
         prdata_next = (hit && !pwrite) ? rdata_in : 32'h0000_0000;
         pslverr_next = !hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= pready_next;
         prdata_reg <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign pready = pready_reg;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;
   assign wr_stb = done && pwrite && hit;
   assign rd_stb = done && !pwrite && hit;

endmodule

/* File: sps_top.sv */
// How it works
// - Level-select bit picks SMBus or I2C thresholds
// - Stop flag marks stop seen last
// - Start flag marks start seen last
// - Start flag I2C only, cleared on disable
// - Buffer full set when received byte complete
// - Transmit buffer full while data bits shift
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ns
module sps_top
   import sps_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Bus engine events
   input wire sps_evt_t evt,
   // Bus engine control
   output sps_ctrl_t ctrl,
   output logic smbus_levels_sel,
   output logic [7:0] tx_byte,
   output logic tx_load,
   output logic [7:0] own_address,
   output logic master_idle
);

   generate
      if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr_w
         $error("sps_top: ADDR_W must be 4 to 32");
      end
   endgenerate

   logic hit;
   logic wr_stb;
   logic rd_stb;
   logic [31:0] rdata;
   logic [7:0] word_addr;

   logic sample_reg;
   logic sample_next;
   logic level_sel_reg;
   logic level_sel_next;
   sps_ctrl_t ctrl_reg;
   sps_ctrl_t ctrl_next;
   logic [7:0] buf_reg;
   logic [7:0] buf_next;
   logic [7:0] tx_byte_reg;
   logic [7:0] tx_byte_next;
   logic tx_load_reg;
   logic tx_load_next;
   logic [7:0] own_addr_reg;
   logic [7:0] own_addr_next;
   logic idle_reg;
   logic idle_next;

   logic en;
   logic i2c_on;
   logic kill;
   logic wr_status;
   logic wr_control;
   logic wr_buffer;
   logic wr_own_addr;
   logic rd_buffer;
   logic tx_write;

   logic start_q;
   logic stop_q;
   logic rw_q;
   logic da_q;
   logic ua_q;
   logic bf_q;
   logic rw_load;
   logic rw_val;
   logic rw_clr;
   logic bf_load;
   logic bf_clr;
   logic [7:0] status_rd;

   assign word_addr = 8'(paddr);
   assign en = ctrl_reg.port_enable;
   assign i2c_on = en && ctrl_reg.i2c_mode;
   assign kill = !ctrl_next.port_enable;

   // Address decode
   always_comb begin
      hit = 1'b0;
      rdata = 32'h0000_0000;
      if (paddr[1:0] == 2'b00 && (32'(paddr) >> 8) == 32'h0000_0000) begin
         case (word_addr)
            SPS_OFF_STATUS: begin
               hit = 1'b1;
               rdata = {24'h00_0000, status_rd};
            end
            SPS_OFF_CONTROL: begin
               hit = 1'b1;
               rdata = {23'h00_0000, ctrl_reg};
            end
            SPS_OFF_BUFFER: begin
               hit = 1'b1;
               rdata = {24'h00_0000, buf_reg};
            end
            SPS_OFF_OWN_ADDR: begin
               hit = 1'b1;
               rdata = {24'h00_0000, own_addr_reg};
            end
            default: begin
               hit = 1'b0;
               rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   sps_apb u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .hit(hit),
      .rdata_in(rdata),
      .pready(pready),
      .prdata(prdata),
      .pslverr(pslverr),
      .wr_stb(wr_stb),
      .rd_stb(rd_stb)
   );

   assign wr_status = wr_stb && word_addr == SPS_OFF_STATUS;
   assign wr_control = wr_stb && word_addr == SPS_OFF_CONTROL;
   assign wr_buffer = wr_stb && word_addr == SPS_OFF_BUFFER;
   assign wr_own_addr = wr_stb && word_addr == SPS_OFF_OWN_ADDR;
   assign rd_buffer = rd_stb && word_addr == SPS_OFF_BUFFER;
   assign tx_write = wr_buffer && i2c_on;

   // Stop flag set by stop, cleared by start
   // stop last event
   sps_flag u_stop (
      .pclk(pclk),
      .presetn(presetn),
      .load(i2c_on && evt.stop_seen),
      .load_val(1'b1),
      .clr(evt.start_seen),
      .kill(kill),
      .q(stop_q)
   );

   sps_flag u_start (
      .pclk(pclk),
      .presetn(presetn),
      .load(i2c_on && evt.start_seen),
      .load_val(1'b1),
      .clr(evt.stop_seen),
      .kill(kill || !ctrl_next.i2c_mode),
      .q(start_q)
   );

   // Direction bit: slave latch or master transmit busy
   always_comb begin
      rw_load = 1'b0;
      rw_val = 1'b0;
      rw_clr = 1'b0;
      if (ctrl_reg.master_mode) begin
         rw_load = tx_write;
         rw_val = 1'b1;
         rw_clr = evt.tx_ack_done || evt.stop_seen;
      end else begin
         rw_load = i2c_on && evt.addr_match;
         rw_val = evt.addr_rw;
         rw_clr = evt.start_seen || evt.stop_seen || evt.nack_seen;
      end
   end

   sps_flag u_rw (
      .pclk(pclk),
      .presetn(presetn),
      .load(rw_load),
      .load_val(rw_val),
      .clr(rw_clr),
      .kill(kill || !ctrl_next.i2c_mode),
      .q(rw_q)
   );

   sps_flag u_da (
      .pclk(pclk),
      .presetn(presetn),
      .load(i2c_on && evt.byte_done),
      .load_val(evt.byte_is_data),
      .clr(1'b0),
      .kill(kill || !ctrl_next.i2c_mode),
      .q(da_q)
   );

   // reload request, cleared by own-address write
   sps_flag u_ua (
      .pclk(pclk),
      .presetn(presetn),
      .load(i2c_on && ctrl_reg.ten_bit && evt.addr_reload_needed),
      .load_val(1'b1),
      .clr(wr_own_addr),
      .kill(kill || !ctrl_next.ten_bit),
      .q(ua_q)
   );

   // Buffer full: receive sets, transmit write sets, drain clears
   always_comb begin
      bf_load = (en && evt.rx_done) || tx_write;
      // cleared when bits done, not ack
      bf_clr = rd_buffer || (i2c_on && evt.tx_bits_done);
   end

   sps_flag u_bf (
      .pclk(pclk),
      .presetn(presetn),
      .load(bf_load),
      .load_val(1'b1),
      .clr(bf_clr),
      .kill(kill),
      .q(bf_q)
   );

   always_comb begin
      status_rd = SPS_STATUS_RST;
      status_rd[SPS_ST_SAMPLE] = sample_reg;
      status_rd[SPS_ST_LEVEL_SEL] = level_sel_reg;
      status_rd[SPS_ST_DATA_ADDR] = da_q;
      status_rd[SPS_ST_STOP] = stop_q;
      status_rd[SPS_ST_START] = start_q;
      status_rd[SPS_ST_RW] = rw_q;
      status_rd[SPS_ST_ADDR_UPDATE] = ua_q;
      status_rd[SPS_ST_BUF_FULL] = bf_q;
   end

   // Software state and outputs
   always_comb begin
      sample_next = sample_reg;
      level_sel_next = level_sel_reg;
      ctrl_next = ctrl_reg;
      buf_next = buf_reg;
      tx_byte_next = tx_byte_reg;
      tx_load_next = tx_write;
      own_addr_next = own_addr_reg;
      if (wr_status) begin
         sample_next = pwdata[SPS_ST_SAMPLE];
         level_sel_next = pwdata[SPS_ST_LEVEL_SEL];
      end
      // Hardware ends request bits as sequences finish
      ctrl_next.req = ctrl_reg.req & ~evt.req_done;
      if (wr_control) begin
         ctrl_next = sps_ctrl_t'(pwdata[8:0]);
      end
      if (!en) begin
         ctrl_next.req = '0;
      end
      if (en && evt.rx_done) begin
         buf_next = evt.rx_byte;
      end
      if (wr_buffer) begin
         buf_next = pwdata[7:0];
         tx_byte_next = pwdata[7:0];
      end
      if (wr_own_addr) begin
         own_addr_next = pwdata[7:0];
      end
   end

   // Master idle only with no request and no transmit
   // idle qualification
   always_comb begin
      idle_next = ctrl_next.port_enable && ctrl_next.i2c_mode && ctrl_next.master_mode && !rw_q && !rw_load
         && ctrl_next.req == '0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_reg <= 1'b0;
         level_sel_reg <= 1'b0;
         ctrl_reg <= sps_ctrl_t'(SPS_CONTROL_RST);
         buf_reg <= SPS_BYTE_RST;
         tx_byte_reg <= SPS_BYTE_RST;
         tx_load_reg <= 1'b0;
         own_addr_reg <= SPS_BYTE_RST;
         idle_reg <= 1'b0;
      end else begin
         sample_reg <= sample_next;
         level_sel_reg <= level_sel_next;
         ctrl_reg <= ctrl_next;
         buf_reg <= buf_next;
         tx_byte_reg <= tx_byte_next;
         tx_load_reg <= tx_load_next;
         own_addr_reg <= own_addr_next;
         idle_reg <= idle_next;
      end
   end

   logic smbus_sel_reg;
   logic smbus_sel_next;

   always_comb begin
      smbus_sel_next = level_sel_next && ctrl_next.i2c_mode && ctrl_next.port_enable;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smbus_sel_reg <= 1'b0;
      end else begin
         smbus_sel_reg <= smbus_sel_next;
      end
   end

   assign ctrl = ctrl_reg;
   assign smbus_levels_sel = smbus_sel_reg;
   assign tx_byte = tx_byte_reg;
   assign tx_load = tx_load_reg;
   assign own_address = own_addr_reg;
   assign master_idle = idle_reg;

endmodule

/* File: sps_peer.sv */
`timescale 1ns/1ns
module sps_peer
   import sps_pkg::*;
(
   // Clock
   input wire logic pclk,
   // Events toward the block
   output sps_evt_t evt
);
   initial evt = '0;
   // One-cycle event pulse, launched after an edge
   task automatic pulse(input sps_evt_t e);
      @(posedge pclk);
      evt <= e;
      @(posedge pclk);
      evt <= '0;
   endtask
endmodule

/* File: sps_props.sv */
`timescale 1ns/1ns
module sps_props
   import sps_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   // Engine side
   input wire sps_evt_t evt,
   input wire sps_ctrl_t ctrl,
   input wire logic smbus_levels_sel,
   input wire logic [7:0] tx_byte,
   input wire logic tx_load,
   input wire logic [7:0] own_address,
   input wire logic master_idle
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire acc = psel && penable && pready;
   wire st_rd = acc && !pwrite && paddr == ADDR_W'(SPS_OFF_STATUS);
   wire buf_wr = acc && pwrite && paddr == ADDR_W'(SPS_OFF_BUFFER);
   wire on = ctrl.port_enable && ctrl.i2c_mode;
   ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("pready late");
   ready_single_a: assert property (pready |=> !pready) else $error("pready too long");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
   level_gate_a: assert property (smbus_levels_sel |-> on) else $error("levels on while off");
   stop_off_a: assert property (st_rd && !ctrl.port_enable && $past(!ctrl.port_enable)
      |-> !prdata[SPS_ST_STOP]) else $error("stop set while disabled");
   start_stop_a: assert property (st_rd |-> !(prdata[SPS_ST_START] && prdata[SPS_ST_STOP]))
      else $error("start and stop both set");
   start_off_a: assert property (st_rd && !on && $past(!on) |-> !prdata[SPS_ST_START])
      else $error("start set while off");
   idle_gate_a: assert property (master_idle |-> on && ctrl.master_mode && ctrl.req == 5'h00)
      else $error("idle with request");
   tx_pulse_a: assert property (buf_wr && on |=> tx_load) else $error("no tx load");
   upd_off_a: assert property (st_rd && !ctrl.ten_bit && $past(!ctrl.ten_bit)
      |-> !prdata[SPS_ST_ADDR_UPDATE]) else $error("update flag without ten bit");
   cover property (st_rd && prdata[SPS_ST_START]);
   cover property (tx_load);
   cover property (master_idle);
endmodule
bind sps_top sps_props #(.ADDR_W(ADDR_W)) i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
   .pslverr(pslverr), .evt(evt), .ctrl(ctrl), .smbus_levels_sel(smbus_levels_sel), .tx_byte(tx_byte),
   .tx_load(tx_load), .own_address(own_address), .master_idle(master_idle));

/* File: sps_top_tb.sv */
`timescale 1ns/1ns
module sps_top_tb
   import sps_pkg::*;
;
   localparam logic [31:0] LVL = 32'h1 << SPS_ST_LEVEL_SEL;
   localparam logic [31:0] DAT = 32'h1 << SPS_ST_DATA_ADDR;
   localparam logic [31:0] STP = 32'h1 << SPS_ST_STOP;
   localparam logic [31:0] STA = 32'h1 << SPS_ST_START;
   localparam logic [31:0] DIR = 32'h1 << SPS_ST_RW;
   localparam logic [31:0] UPD = 32'h1 << SPS_ST_ADDR_UPDATE;
   localparam logic [31:0] FUL = 32'h1 << SPS_ST_BUF_FULL;
   localparam logic [31:0] EN = (32'h1 << SPS_CT_ENABLE) | (32'h1 << SPS_CT_I2C);
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic pready, pslverr, tx_load, smbus_levels_sel, master_idle, err;
   logic [31:0] prdata, r;
   logic [7:0] tx_byte, own_address;
   sps_evt_t evt, e;
   sps_ctrl_t ctrl;
   int mismatches = 0;
   int checks = 0;
   always #25 pclk = ~pclk;
   sps_peer i_peer (.pclk(pclk), .evt(evt));
   sps_top #(.ADDR_W(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .evt(evt), .ctrl(ctrl), .smbus_levels_sel(smbus_levels_sel), .tx_byte(tx_byte), .tx_load(tx_load),
      .own_address(own_address), .master_idle(master_idle));
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic status(input logic [31:0] exp);
      apb(1'b0, SPS_OFF_STATUS, 32'h0);
      check(r, exp);
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #(4000 * 50);
      mismatches++;
      tally_and_finish;
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      status(32'h0);
      apb(1'b0, 8'h10, 32'h0);
      check({31'h0, err}, 32'h1);
      $display("test reset done");
      apb(1'b1, SPS_OFF_CONTROL, EN | (32'h1 << SPS_CT_TEN_BIT));
      apb(1'b1, SPS_OFF_STATUS, LVL);
      repeat (2) @(posedge pclk);
      check({31'h0, smbus_levels_sel}, 32'h1);
      check({23'h0, ctrl}, EN | (32'h1 << SPS_CT_TEN_BIT));
      e = '0;
      e.start_seen = 1'b1;
      i_peer.pulse(e);
      status(LVL | STA);
      e = '0;
      e.addr_match = 1'b1;
      e.addr_rw = 1'b1;
      e.byte_done = 1'b1;
      i_peer.pulse(e);
      status(LVL | STA | DIR);
      e = '0;
      e.stop_seen = 1'b1;
      i_peer.pulse(e);
      status(LVL | STP);
      $display("test slave done");
      e = '0;
      e.rx_done = 1'b1;
      e.rx_byte = 8'ha5;
      e.byte_done = 1'b1;
      e.byte_is_data = 1'b1;
      i_peer.pulse(e);
      status(LVL | DAT | STP | FUL);
      apb(1'b0, SPS_OFF_BUFFER, 32'h0);
      check(r, 32'ha5);
      status(LVL | DAT | STP);
      e = '0;
      e.addr_reload_needed = 1'b1;
      i_peer.pulse(e);
      status(LVL | DAT | STP | UPD);
      apb(1'b1, SPS_OFF_OWN_ADDR, 32'h5a);
      status(LVL | DAT | STP);
      check({24'h0, own_address}, 32'h5a);
      $display("test receive done");
      apb(1'b1, SPS_OFF_CONTROL, EN | (32'h1 << SPS_CT_MASTER));
      apb(1'b1, SPS_OFF_BUFFER, 32'h3c);
      status(LVL | DAT | STP | DIR | FUL);
      check({24'h0, tx_byte}, 32'h3c);
      e = '0;
      e.tx_bits_done = 1'b1;
      i_peer.pulse(e);
      status(LVL | DAT | STP | DIR);
      e = '0;
      e.tx_ack_done = 1'b1;
      i_peer.pulse(e);
      status(LVL | DAT | STP);
      check({31'h0, master_idle}, 32'h1);
      apb(1'b1, SPS_OFF_CONTROL, EN | (32'h1 << SPS_CT_MASTER) | (32'h1 << SPS_CT_REQ_LSB));
      @(posedge pclk);
      check({31'h0, master_idle}, 32'h0);
      e = '0;
      e.req_done.start = 1'b1;
      i_peer.pulse(e);
      @(posedge pclk);
      check({31'h0, master_idle}, 32'h1);
      check({23'h0, ctrl}, EN | (32'h1 << SPS_CT_MASTER));
      $display("test master done");
      e = '0;
      e.start_seen = 1'b1;
      i_peer.pulse(e);
      status(LVL | DAT | STA);
      apb(1'b1, SPS_OFF_CONTROL, 32'h0);
      status(LVL);
      check(r & (STA | STP), 32'h0);
      check({31'h0, smbus_levels_sel}, 32'h0);
      $display("test disable done");
      tally_and_finish;
   end
endmodule
